// ---- logic/adq_adapt_ctl.v ----
// Contract
// - any error select bit enables error checking
// - select bits: clock, encoding, parity errors
// - accumulate errors over half relock period
// - count above limit raises equalizer setting
// - two-step validation also uses enabled errors
// - one-step: full wait, then instantaneous lock
// - two-step: half wait, half error window
// - nesting bit picks inner and outer loop
// - filter enable adds sample filter search
// - filter stays within programmed lower/upper bounds
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adq_adapt_regs.vh"

module adq_adapt_ctl (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire pready_out,
	output wire [31:0] prdata_out,
	output wire pslverr_out,
	input wire lock_in,
	input wire err_clk_in,
	input wire err_enc_in,
	input wire err_par_in,
	output wire [3:0] eq_setting_out,
	output wire [3:0] sf_setting_out,
	output wire adapt_busy_out
);

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_SETTLE = 5'b00010;
	localparam [4:0] ST_COUNT = 5'b00100;
	localparam [4:0] ST_MON = 5'b01000;
	localparam [15:0] UNIT_CYCLES = `ADQ_RELOCK_UNIT_CYCLES;
	reg [7:0] sf_bounds_reg;
	reg [7:0] eq_ctl_reg;
	reg [7:0] err_limit_reg;
	reg [7:0] relock_reg;
	reg [31:0] prdata_reg;
	reg pslverr_reg;
	reg lock_s1_reg;
	reg lock_s2_reg;
	reg lock_s3_reg;
	reg lock_reg;
	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg [23:0] timer_reg;
	reg [23:0] timer_next;
	reg [7:0] acc_reg;
	reg [7:0] acc_next;
	reg [3:0] eq_reg;
	reg [3:0] eq_next;
	reg [3:0] sf_reg;
	reg [3:0] sf_next;
	reg [3:0] step_eq;
	reg [3:0] step_sf;
	reg [31:0] rd_data;
	reg rd_hit;
	wire [2:0] err_sel;
	wire two_step;
	wire loop_sel;
	wire sf_en;
	wire [3:0] sf_upper;
	wire [3:0] sf_lower;
	wire [23:0] period_full;
	wire [23:0] load_full;
	wire [23:0] load_half;
	wire [23:0] load_first;
	wire [1:0] err_now;
	wire [8:0] acc_sum;
	wire [7:0] acc_sat;
	wire timer_end;
	wire apb_setup;
	wire apb_write;
	wire [9:0] reg_idx;
	wire aligned;
	wire start_cmd;
	wire stop_cmd;
	// checks a bus word address against a register index
	function is_idx;
		input [9:0] idx;
		input [9:0] target;
		input ok;
		begin
			is_idx = ok && (idx == target);
		end
	endfunction

	// next value of a bounded counter that wraps from top to bottom
	function [3:0] wrap_inc;
		input [3:0] value;
		input [3:0] low;
		input [3:0] high;
		begin
			wrap_inc = (value >= high) ? low : value + 4'h1;
		end
	endfunction

	// control fields
	assign err_sel = eq_ctl_reg[`ADQ_CTL_ERRSEL_HI:`ADQ_CTL_ERRSEL_LO];
	assign two_step = eq_ctl_reg[`ADQ_CTL_TWO_STEP];
	assign loop_sel = eq_ctl_reg[`ADQ_CTL_LOOP_SEL];
	assign sf_en = eq_ctl_reg[`ADQ_CTL_SF_EN];
	assign sf_upper = sf_bounds_reg[`ADQ_SF_UPPER_HI:`ADQ_SF_UPPER_LO];
	assign sf_lower = sf_bounds_reg[`ADQ_SF_LOWER_HI:`ADQ_SF_LOWER_LO];

	// relock period in cycles, full and half, never below one cycle
	assign period_full = relock_reg * UNIT_CYCLES;
	assign load_full = (period_full == 24'h000000) ? 24'h000001 : period_full;
	assign load_half = (period_full[23:1] == 23'h000000) ? 24'h000001 : {1'b0, period_full[23:1]};
	assign load_first = two_step ? load_half : load_full;
	assign timer_end = (timer_reg == 24'h000001);

	// enabled error events of this cycle; nothing counts with all selects clear
	assign err_now = {1'b0, err_clk_in & err_sel[2]} + {1'b0, err_enc_in & err_sel[1]}
		+ {1'b0, err_par_in & err_sel[0]};
	assign acc_sum = {1'b0, acc_reg} + {7'h00, err_now};
	assign acc_sat = acc_sum[8] ? 8'hFF : acc_sum[7:0];

	// bus decode
	assign apb_setup = psel_in && !penable_in;
	assign apb_write = psel_in && penable_in && pwrite_in;
	assign reg_idx = paddr_in[11:2];
	assign aligned = (paddr_in[1:0] == 2'b00);
	assign start_cmd = apb_write && is_idx(reg_idx, `ADQ_IDX_COMMAND, aligned) && pwdata_in[`ADQ_CMD_START];
	assign stop_cmd = apb_write && is_idx(reg_idx, `ADQ_IDX_COMMAND, aligned) && pwdata_in[`ADQ_CMD_STOP];
	assign pready_out = 1'b1;
	assign prdata_out = prdata_reg;
	assign pslverr_out = pslverr_reg;

	// read mux and unmapped address detection
	always @* begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		if (is_idx(reg_idx, `ADQ_IDX_SF_BOUNDS, aligned)) begin
			rd_data = {24'h000000, sf_bounds_reg};
		end else if (is_idx(reg_idx, `ADQ_IDX_EQ_CTL, aligned)) begin
			rd_data = {24'h000000, eq_ctl_reg};
		end else if (is_idx(reg_idx, `ADQ_IDX_ERR_LIMIT, aligned)) begin
			rd_data = {24'h000000, err_limit_reg};
		end else if (is_idx(reg_idx, `ADQ_IDX_RELOCK, aligned)) begin
			rd_data = {24'h000000, relock_reg};
		end else if (is_idx(reg_idx, `ADQ_IDX_COMMAND, aligned)) begin
			rd_data = 32'h00000000;
		end else if (is_idx(reg_idx, `ADQ_IDX_STATUS, aligned)) begin
			rd_data = {9'h000, state_reg, acc_reg, lock_reg, adapt_busy_out, sf_reg, eq_reg};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read data and error are captured in the setup cycle
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (apb_setup) begin
			prdata_reg <= pwrite_in ? 32'h00000000 : rd_data;
			pslverr_reg <= !rd_hit;
		end
	end

	// software registers; bit 7 of the control register stays zero
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sf_bounds_reg <= `ADQ_RST_SF_BOUNDS;
			eq_ctl_reg <= `ADQ_RST_EQ_CTL;
			err_limit_reg <= `ADQ_RST_ERR_LIMIT;
			relock_reg <= `ADQ_RST_RELOCK;
		end else if (apb_write) begin
			if (is_idx(reg_idx, `ADQ_IDX_SF_BOUNDS, aligned)) begin
				sf_bounds_reg <= pwdata_in[7:0];
			end
			if (is_idx(reg_idx, `ADQ_IDX_EQ_CTL, aligned)) begin
				eq_ctl_reg <= {1'b0, pwdata_in[6:0]};
			end
			if (is_idx(reg_idx, `ADQ_IDX_ERR_LIMIT, aligned)) begin
				err_limit_reg <= pwdata_in[7:0];
			end
			if (is_idx(reg_idx, `ADQ_IDX_RELOCK, aligned)) begin
				relock_reg <= pwdata_in[7:0];
			end
		end
	end

	// lock status from the analog side: three stages, change once two agree
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lock_s1_reg <= 1'b0;
			lock_s2_reg <= 1'b0;
			lock_s3_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			lock_s1_reg <= lock_in;
			lock_s2_reg <= lock_s1_reg;
			lock_s3_reg <= lock_s2_reg;
			if (lock_s2_reg == lock_s3_reg) begin
				lock_reg <= lock_s3_reg;
			end
		end
	end

	// next candidate of the search
	always @* begin
		step_eq = eq_reg;
		step_sf = sf_reg;
		if (!sf_en) begin
			step_eq = wrap_inc(eq_reg, `ADQ_EQ_MIN, `ADQ_EQ_MAX);
		end else if (!loop_sel) begin
			step_eq = wrap_inc(eq_reg, `ADQ_EQ_MIN, `ADQ_EQ_MAX);
			if (eq_reg >= `ADQ_EQ_MAX) begin
				step_sf = wrap_inc(sf_reg, sf_lower, sf_upper);
			end
		end else begin
			step_sf = wrap_inc(sf_reg, sf_lower, sf_upper);
			if (sf_reg >= sf_upper) begin
				step_eq = wrap_inc(eq_reg, `ADQ_EQ_MIN, `ADQ_EQ_MAX);
			end
		end
	end

	// adaptation state machine
	always @* begin
		state_next = state_reg;
		timer_next = timer_reg;
		acc_next = acc_reg;
		eq_next = eq_reg;
		sf_next = sf_reg;
		if (timer_reg != 24'h000000) begin
			timer_next = timer_reg - 24'h000001;
		end
		case (state_reg)
		ST_IDLE: begin
			if (start_cmd) begin
				eq_next = `ADQ_EQ_MIN;
				sf_next = sf_en ? sf_lower : sf_reg;
				timer_next = load_first;
				state_next = ST_SETTLE;
			end
		end
		ST_SETTLE: begin
			if (timer_end) begin
				acc_next = 8'h00;
				if (two_step) begin
					timer_next = load_half;
					state_next = ST_COUNT;
				end else if (lock_reg) begin
					timer_next = load_half;
					state_next = ST_MON;
				end else begin
					eq_next = step_eq;
					sf_next = step_sf;
					timer_next = load_first;
				end
			end
		end
		ST_COUNT: begin
			acc_next = acc_sat;
			if (err_now != 2'b00) begin
				eq_next = step_eq;
				sf_next = step_sf;
				timer_next = load_first;
				state_next = ST_SETTLE;
			end else if (timer_end) begin
				acc_next = 8'h00;
				if (lock_reg) begin
					timer_next = load_half;
					state_next = ST_MON;
				end else begin
					eq_next = step_eq;
					sf_next = step_sf;
					timer_next = load_first;
					state_next = ST_SETTLE;
				end
			end
		end
		ST_MON: begin
			acc_next = acc_sat;
			if (!lock_reg) begin
				eq_next = `ADQ_EQ_MIN;
				sf_next = sf_en ? sf_lower : sf_reg;
				timer_next = load_first;
				state_next = ST_SETTLE;
			end else if (timer_end) begin
				acc_next = 8'h00;
				timer_next = load_half;
				if ((acc_sat > err_limit_reg) && (eq_reg < `ADQ_EQ_MAX)) begin
					eq_next = eq_reg + 4'h1;
					timer_next = load_first;
					state_next = ST_SETTLE;
				end
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
		if (stop_cmd) begin
			state_next = ST_IDLE;
			timer_next = 24'h000000;
			acc_next = acc_reg;
			eq_next = eq_reg;
			sf_next = sf_reg;
		end
	end

	// state registers
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= 24'h000000;
			acc_reg <= 8'h00;
			eq_reg <= `ADQ_RST_EQ_SETTING;
			sf_reg <= `ADQ_RST_SF_SETTING;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			acc_reg <= acc_next;
			eq_reg <= eq_next;
			sf_reg <= sf_next;
		end
	end

	// settings to the analog equalizer and sample filter
	assign eq_setting_out = eq_reg;
	assign sf_setting_out = sf_reg;
	assign adapt_busy_out = (state_reg == ST_SETTLE) || (state_reg == ST_COUNT);

endmodule // adq_adapt_ctl
`default_nettype wire

// ---- logic/adq_adapt_regs.vh ----
`ifndef ADQ_ADAPT_REGS_VH
`define ADQ_ADAPT_REGS_VH

// register indices; byte address is four times the index
`define ADQ_IDX_SF_BOUNDS 10'h041
`define ADQ_IDX_EQ_CTL 10'h042
`define ADQ_IDX_ERR_LIMIT 10'h043
`define ADQ_IDX_RELOCK 10'h050
`define ADQ_IDX_COMMAND 10'h051
`define ADQ_IDX_STATUS 10'h052

// reset values
`define ADQ_RST_SF_BOUNDS 8'hA7
`define ADQ_RST_EQ_CTL 8'h71
`define ADQ_RST_ERR_LIMIT 8'h01
`define ADQ_RST_RELOCK 8'h10
`define ADQ_RST_SF_SETTING 4'h7
`define ADQ_RST_EQ_SETTING 4'h0

// field positions in the sample filter bounds register
`define ADQ_SF_UPPER_HI 7
`define ADQ_SF_UPPER_LO 4
`define ADQ_SF_LOWER_HI 3
`define ADQ_SF_LOWER_LO 0

// field positions in the equalizer adapt control register
`define ADQ_CTL_ERRSEL_HI 6
`define ADQ_CTL_ERRSEL_LO 4
`define ADQ_CTL_ERRSEL_CLK 6
`define ADQ_CTL_ERRSEL_ENC 5
`define ADQ_CTL_ERRSEL_PAR 4
`define ADQ_CTL_RSVD3 3
`define ADQ_CTL_TWO_STEP 2
`define ADQ_CTL_LOOP_SEL 1
`define ADQ_CTL_SF_EN 0

// command register bits
`define ADQ_CMD_START 0
`define ADQ_CMD_STOP 1

// equalizer setting range
`define ADQ_EQ_MIN 4'h0
`define ADQ_EQ_MAX 4'hF

// timing: relock period register counts in units of this time
`define ADQ_CLK_PERIOD_NS 100
`define ADQ_RELOCK_UNIT_NS 10000
`define ADQ_RELOCK_UNIT_CYCLES 16'h0064

`endif

// ---- tb/adq_adapt_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adq_adapt_regs.vh"
module adq_adapt_checker (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	input wire logic [3:0] eq_setting_out,
	input wire logic [3:0] sf_setting_out,
	input wire logic adapt_busy_out
);
	logic [7:0] ctl_reg, sfb_reg, lim_reg;
	wire logic acc = psel_in && penable_in;
	wire logic rd = acc && !pwrite_in;
	wire logic [9:0] idx = paddr_in[11:2];
	// decode of the mapped, aligned words
	wire logic hit = paddr_in[1:0] == 2'h0 && (idx == `ADQ_IDX_SF_BOUNDS
		|| idx == `ADQ_IDX_EQ_CTL || idx == `ADQ_IDX_ERR_LIMIT || idx == `ADQ_IDX_RELOCK
		|| idx == `ADQ_IDX_COMMAND || idx == `ADQ_IDX_STATUS);
	// shadow copies of the control, bounds and limit registers
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctl_reg <= `ADQ_RST_EQ_CTL;
			sfb_reg <= `ADQ_RST_SF_BOUNDS;
			lim_reg <= `ADQ_RST_ERR_LIMIT;
		end else if (acc && pwrite_in && hit) begin
			if (idx == `ADQ_IDX_EQ_CTL) ctl_reg <= pwdata_in[7:0] & 8'h7F;
			if (idx == `ADQ_IDX_SF_BOUNDS) sfb_reg <= pwdata_in[7:0];
			if (idx == `ADQ_IDX_ERR_LIMIT) lim_reg <= pwdata_in[7:0];
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	bad_addr_a: assert property (acc |-> pslverr_out == !hit)
		else $error("slave error flag wrong");
	ctl_read_a: assert property (
		rd && hit && idx == `ADQ_IDX_EQ_CTL |-> prdata_out == {24'h0, ctl_reg})
		else $error("control readback wrong");
	bounds_read_a: assert property (
		rd && hit && idx == `ADQ_IDX_SF_BOUNDS |-> prdata_out == {24'h0, sfb_reg})
		else $error("bounds readback wrong");
	limit_read_a: assert property (
		rd && hit && idx == `ADQ_IDX_ERR_LIMIT |-> prdata_out == {24'h0, lim_reg})
		else $error("limit readback wrong");
	eq_step_a: assert property ($changed(eq_setting_out) |->
		eq_setting_out == $past(eq_setting_out) + 4'h1 || eq_setting_out == 4'h0)
		else $error("equalizer jumped");
	eq_busy_a: assert property ($changed(eq_setting_out) |-> adapt_busy_out)
		else $error("equalizer moved outside validation");
	sf_hold_a: assert property (!ctl_reg[0] |=> $stable(sf_setting_out))
		else $error("filter moved while disabled");
	reset_val_a: assert property ($rose(reset_n_in) |->
		eq_setting_out == 4'h0 && sf_setting_out == 4'h7 && !adapt_busy_out)
		else $error("reset settings wrong");
	cover property (acc && !hit);
	cover property ($fell(adapt_busy_out));
	cover property ($changed(sf_setting_out));
endmodule // adq_adapt_checker
bind adq_adapt_ctl adq_adapt_checker i_chk (.core_clk_in, .reset_n_in, .psel_in, .penable_in,
	.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pslverr_out, .eq_setting_out,
	.sf_setting_out, .adapt_busy_out);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk_in = 1'b0, reset_n_in = 1'b0, lock_in = 1'b0, rerr;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic err_clk_in = 1'b0, err_enc_in = 1'b0, err_par_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, rdat;
	wire logic pready_out, pslverr_out, adapt_busy_out;
	wire logic [31:0] prdata_out;
	wire logic [3:0] eq_setting_out, sf_setting_out;
	int error_cnt = 0, tests_run = 0;
	adq_adapt_ctl i_dut (.core_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .lock_in, .err_clk_in,
		.err_enc_in, .err_par_in, .eq_setting_out, .sf_setting_out, .adapt_busy_out);
	// core clock, 100 ns period
	always #50 core_clk_in = ~core_clk_in;
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			error_cnt++;
			$display("FAIL at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// one bus transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= {24'h0, d};
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do @(posedge core_clk_in); while (pready_out !== 1'b1);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk(rdat, x);
	endtask
	task automatic st(input logic b, input logic [3:0] q, input logic [3:0] f);
		chk({23'h0, adapt_busy_out, eq_setting_out, sf_setting_out}, {23'h0, b, q, f});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n) begin
			@(posedge core_clk_in);
			{err_clk_in, err_enc_in, err_par_in} <= m;
		end
		@(posedge core_clk_in);
		{err_clk_in, err_enc_in, err_par_in} <= 3'h0;
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// cuts a hang short
	initial begin
		cyc(6000);
		error_cnt++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		rd(12'h104, 32'hA7);
		rd(12'h108, 32'h71);
		rd(12'h10C, 32'h01);
		rd(12'h140, 32'h10);
		rd(12'h148, 32'h00040070);
		st(1'b0, 4'h0, 4'h7);
		apb(1'b1, 12'h20C, 8'h55);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, 12'h109, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 12'h108, 8'hFF);
		rd(12'h108, 32'h7F);
		$display("register test done");
		apb(1'b1, 12'h140, 8'h01);
		apb(1'b1, 12'h108, 8'h70);
		lock_in <= 1'b1;
		apb(1'b1, 12'h144, 8'h01);
		cyc(90);
		st(1'b1, 4'h0, 4'h7);
		cyc(20);
		st(1'b0, 4'h0, 4'h7);
		pulse(3'h1, 1);
		cyc(110);
		st(1'b0, 4'h0, 4'h7);
		apb(1'b1, 12'h108, 8'h00);
		pulse(3'h7, 3);
		cyc(110);
		st(1'b0, 4'h0, 4'h7);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, 12'h108, {1'b0, 3'h4 >> k, 4'h0});
			pulse(~(3'h4 >> k), 3);
			cyc(110);
			st(1'b0, k[3:0], 4'h7);
			pulse(3'h4 >> k, 3);
			cyc(60);
			chk({28'h0, eq_setting_out}, 32'(k + 1));
		end
		$display("monitor test done");
		apb(1'b1, 12'h144, 8'h02);
		apb(1'b1, 12'h108, 8'h74);
		apb(1'b1, 12'h144, 8'h01);
		cyc(70);
		pulse(3'h4, 1);
		cyc(3);
		st(1'b1, 4'h1, 4'h7);
		cyc(80);
		st(1'b1, 4'h1, 4'h7);
		cyc(30);
		st(1'b0, 4'h1, 4'h7);
		$display("two-step test done");
		apb(1'b1, 12'h144, 8'h02);
		lock_in <= 1'b0;
		apb(1'b1, 12'h104, 8'h98);
		apb(1'b1, 12'h108, 8'h73);
		apb(1'b1, 12'h144, 8'h01);
		cyc(50);
		st(1'b1, 4'h0, 4'h8);
		cyc(100);
		st(1'b1, 4'h0, 4'h9);
		cyc(100);
		st(1'b1, 4'h1, 4'h8);
		apb(1'b1, 12'h144, 8'h02);
		apb(1'b1, 12'h108, 8'h71);
		apb(1'b1, 12'h144, 8'h01);
		cyc(1650);
		st(1'b1, 4'h0, 4'h9);
		$display("filter test done");
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
